// >>> design/srpc_top.sv
// reference-path and charge-pump control bank of a fractional-n synthesizer
// assumes a classic wishbone master on clock_i and a reference pin that is
// asynchronous to clock_i and well below half its rate
//
// Overview of operation
// - phase enable makes main writes shift phase
// - with phase enable set, each main write adds programmed phase value
// - phase held as 24-bit unsigned turn fraction
// - code 0100 loads reference/pump control register
// - three-bit field picks test output source
// - doubler bit doubles reference before counter
// - doubler off: falling edge; on: both edges
// - halving bit adds toggle, even duty clock
// - ten-bit reference counter divides 1 to 1023
// - double buffer delays divider select to main
// - four-bit field sets pump current
// - level bit picks 1.8 or 3.3 volt
// - polarity bit: one positive, zero negative
// - power-down bit stops synthesizer, keeps registers
// - power-down loads counters, kills vco, outputs
// - words still load during power-down
// - three-state bit floats the pump
// - counter reset bit holds counters
// - code 0000 writes main, strobes buffers
// - main write resets modulator unless disabled
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module srpc_top
  import srpc_pkg::*;
#(
  parameter int RDIV_W = 10 // reference counter width
) (
  input wire logic clock_i, // system clock, 40 mhz
  input wire logic resetn_i, // asynchronous reset, active low
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reference path
  input wire logic reference_input_i, // reference pin, asynchronous
  output logic pfd_clock_o, // comparison clock to phase detector
  // control outputs toward the analog side
  output logic [2:0] test_output_mux_o,
  output logic mux_logic_level_select_o,
  output logic detector_polarity_o,
  output logic [3:0] pump_current_field_o,
  output logic pump_three_state_o,
  output logic differential_reference_o,
  output logic counters_hold_o,
  output logic counters_load_o,
  output logic vco_enable_o,
  output logic rf_outputs_enable_o,
  output logic lock_detect_reset_o,
  output logic vco_autocal_start_o,
  output logic modulator_reset_o,
  output logic [2:0] output_divider_select_o,
  output logic [23:0] phase_accum_o
);

  // all state of the block
  typedef struct packed {
    logic ack; // bus answer
    logic [31:0] rdat; // bus read data
    logic [31:0] word; // last word taken
    logic [31:0] main; // main integer register
    logic [31:0] phase; // phase register
    logic [31:0] refctl; // reference and pump control
    logic [31:0] outreg; // output register
    logic [31:0] resv; // reserved fixed word
    logic [2:0] div_act; // divider select in effect
    logic [23:0] ph_acc; // accumulated output phase
    logic mod_rst; // modulator reset pulse
    logic cal_start; // autocal start pulse
    logic ref_s1; // reference synchroniser, first stage
    logic ref_s2; // reference synchroniser, second stage
    logic ref_prev; // previous synchronised level
    logic [RDIV_W-1:0] rcnt; // reference counter
    logic term; // counter terminal pulse
    logic half; // divide-by-two toggle
    logic pfd; // comparison clock
    logic [2:0] mux; // registered control copies
    logic level;
    logic pol;
    logic [3:0] pump;
    logic tri_st;
    logic refmode;
    logic hold;
    logic load;
    logic vco_en;
    logic rf_en;
    logic ld_rst;
  } srpc_state_s;

  srpc_state_s cur; // registered state
  srpc_state_s next_cur; // next state

  // byte-lane merge for direct register writes
  function automatic logic [31:0] srpc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // reset image of the state
  function automatic srpc_state_s srpc_reset_value();
    srpc_state_s s;
    s = '0;
    s.word = SRPC_RST_WORD;
    s.main = SRPC_RST_MAIN;
    s.phase = SRPC_RST_PHASE;
    s.refctl = SRPC_RST_REFCTL;
    s.outreg = SRPC_RST_OUTREG;
    s.resv = SRPC_RST_RESV;
    s.pump = SRPC_RST_REFCTL[SRPC_RC_PUMP_LSB +: 4];
    s.vco_en = 1'b1;
    s.rf_en = 1'b1;
    return s;
  endfunction

  // next-state logic
  always_comb begin
    logic req; // fresh bus request
    logic wr_ok; // write cycle taken this edge
    logic take; // a configuration word is delivered
    logic [31:0] cw; // the delivered word
    logic main_wr; // main register written
    logic ev; // active reference edge
    logic pdown; // power-down in effect
    logic [RDIV_W-1:0] rdiv; // programmed division ratio
    logic [31:0] rc; // control register as it will stand
    req = 1'b0;
    wr_ok = 1'b0;
    take = 1'b0;
    cw = '0;
    main_wr = 1'b0;
    ev = 1'b0;
    pdown = 1'b0;
    rdiv = '0;
    rc = '0;
    next_cur = cur;
    next_cur.mod_rst = 1'b0;
    next_cur.cal_start = 1'b0;

    // wishbone: answer one cycle after the request, drop ack next cycle
    req = wb_cyc_i && wb_stb_i && !cur.ack;
    next_cur.ack = req;
    wr_ok = req && wb_we_i;

    // writes: word port dispatches on its code, direct ports by address
    if (wr_ok) begin
      unique case (wb_adr_i)
        SRPC_OFS_WORD: begin
          // a word only counts when all 32 bits are written
          if (wb_sel_i == 4'hF) begin
            take = 1'b1;
            cw = wb_dat_i;
          end
        end
        SRPC_OFS_REFCTL: begin
          take = 1'b1;
          cw = srpc_merge(cur.refctl, wb_dat_i, wb_sel_i);
          cw[3:0] = SRPC_CODE_REFCTL;
        end
        SRPC_OFS_RESV: begin
          take = 1'b1;
          cw = srpc_merge(cur.resv, wb_dat_i, wb_sel_i);
          cw[3:0] = SRPC_CODE_RESV;
        end
        default: begin
          // read-only or unmapped: write ignored, still answered
        end
      endcase
    end

    // words keep loading whatever the power state
    if (take) begin
      next_cur.word = cw;
      unique case (cw[3:0]) // destination by code
        SRPC_CODE_MAIN: begin
          next_cur.main = cw;
          main_wr = 1'b1;
        end
        SRPC_CODE_PHASE: next_cur.phase = cw; // phase held 24-bit
        SRPC_CODE_REFCTL: next_cur.refctl = cw;
        SRPC_CODE_RESV: next_cur.resv = cw;
        SRPC_CODE_OUTREG: begin
          next_cur.outreg = cw;
          // unbuffered divider select follows at once
          if (!cur.refctl[SRPC_RC_DBUF]) begin
            next_cur.div_act = cw[SRPC_OR_DIV_LSB +: 3];
          end
        end
        default: begin
          // other codes belong to registers outside this bank
        end
      endcase
    end

    // main write is the update strobe
    if (main_wr) begin
      // phase advances by the programmed value
      if (cur.phase[SRPC_PH_ADJ_EN]) begin
        next_cur.ph_acc = cur.ph_acc + cur.phase[SRPC_PH_VAL_LSB +: SRPC_PH_W];
      end
      // modulator reset unless disabled
      next_cur.mod_rst = !cur.phase[SRPC_PH_LOAD_RST_DIS];
      next_cur.cal_start = cw[SRPC_MAIN_AUTOCAL];
      // buffered divider select takes effect now
      if (cur.refctl[SRPC_RC_DBUF]) begin
        next_cur.div_act = cur.outreg[SRPC_OR_DIV_LSB +: 3];
      end
    end

    // control copies follow the register as it stands after this edge
    rc = next_cur.refctl;
    pdown = rc[SRPC_RC_PDOWN];
    next_cur.mux = rc[SRPC_RC_MUX_LSB +: 3];
    next_cur.level = rc[SRPC_RC_LEVEL];
    next_cur.pol = rc[SRPC_RC_POL];
    next_cur.pump = rc[SRPC_RC_PUMP_LSB +: 4];
    next_cur.refmode = rc[SRPC_RC_REFMODE];
    // pump floats on its own bit or in power-down
    next_cur.tri_st = rc[SRPC_RC_TRI] || pdown;
    // power-down effects; registers above are untouched
    next_cur.load = pdown;
    next_cur.vco_en = !pdown;
    next_cur.rf_en = !pdown;
    next_cur.ld_rst = pdown;
    next_cur.hold = rc[SRPC_RC_CRST] || pdown;

    // the pin passes two flops before use, so its edges show up two
    // clocks late; ref_prev starts low to match the idle pin level
    // reference synchroniser and edge pick
    next_cur.ref_s1 = reference_input_i;
    next_cur.ref_s2 = cur.ref_s1;
    next_cur.ref_prev = cur.ref_s2;
    if (cur.refctl[SRPC_RC_DOUBLER]) begin
      ev = cur.ref_s2 != cur.ref_prev; // both edges
    end else begin
      ev = cur.ref_prev && !cur.ref_s2; // falling edge only
    end

    // the compare uses >= so a ratio lowered below the running count
    // wraps at once instead of running through the whole counter range
    // reference counter, ratio 1..1023; zero acts as one
    rdiv = cur.refctl[SRPC_RC_RDIV_LSB +: RDIV_W];
    next_cur.term = 1'b0;
    if (cur.hold || cur.load) begin
      // counter held in reset or load state
      next_cur.rcnt = '0;
      next_cur.half = 1'b0;
    end else if (ev) begin
      if (cur.rcnt + 1'b1 >= rdiv) begin
        next_cur.rcnt = '0;
        next_cur.term = 1'b1;
        next_cur.half = !cur.half; // toggle stage
      end else begin
        next_cur.rcnt = cur.rcnt + 1'b1;
      end
    end

    // comparison clock: even-duty toggle or raw terminal
    if (cur.refctl[SRPC_RC_HALVE]) begin
      next_cur.pfd = cur.half;
    end else begin
      next_cur.pfd = cur.term;
    end

    // read data, captured with ack; unmapped reads as zero
    next_cur.rdat = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        SRPC_OFS_WORD: next_cur.rdat = cur.word;
        SRPC_OFS_REFCTL: next_cur.rdat = cur.refctl;
        SRPC_OFS_MAIN: next_cur.rdat = cur.main;
        SRPC_OFS_PHASE: next_cur.rdat = cur.phase;
        SRPC_OFS_OUTREG: next_cur.rdat = cur.outreg;
        SRPC_OFS_RESV: next_cur.rdat = cur.resv;
        SRPC_OFS_PHACC: next_cur.rdat = {8'h00, cur.ph_acc};
        SRPC_OFS_STATUS: begin
          next_cur.rdat[0] = cur.load;
          next_cur.rdat[1] = cur.hold;
          next_cur.rdat[2] = cur.tri_st;
          next_cur.rdat[3] = cur.resv == SRPC_RESV_FIXED;
          next_cur.rdat[6:4] = cur.div_act;
          next_cur.rdat[7] = cur.half;
          next_cur.rdat[8 +: RDIV_W] = cur.rcnt;
        end
        default: next_cur.rdat = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= srpc_reset_value();
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state flip-flops
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.rdat;
  assign pfd_clock_o = cur.pfd;
  assign test_output_mux_o = cur.mux;
  assign mux_logic_level_select_o = cur.level;
  assign detector_polarity_o = cur.pol;
  assign pump_current_field_o = cur.pump;
  assign pump_three_state_o = cur.tri_st;
  assign differential_reference_o = cur.refmode;
  assign counters_hold_o = cur.hold;
  assign counters_load_o = cur.load;
  assign vco_enable_o = cur.vco_en;
  assign rf_outputs_enable_o = cur.rf_en;
  assign lock_detect_reset_o = cur.ld_rst;
  assign vco_autocal_start_o = cur.cal_start;
  assign modulator_reset_o = cur.mod_rst;
  assign output_divider_select_o = cur.div_act;
  assign phase_accum_o = cur.ph_acc;

endmodule

`default_nettype wire

// >>> design/srpc_pkg.sv
// constants for the synthesizer reference-path control bank
// assumes a 32-bit classic wishbone slave with byte addresses
package srpc_pkg;
  // register byte offsets
  localparam logic [7:0] SRPC_OFS_WORD = 8'h00; // config word port
  localparam logic [7:0] SRPC_OFS_REFCTL = 8'h04; // reference/pump control
  localparam logic [7:0] SRPC_OFS_MAIN = 8'h08; // main integer readback
  localparam logic [7:0] SRPC_OFS_PHASE = 8'h0C; // phase register readback
  localparam logic [7:0] SRPC_OFS_OUTREG = 8'h10; // output register readback
  localparam logic [7:0] SRPC_OFS_RESV = 8'h14; // reserved fixed word
  localparam logic [7:0] SRPC_OFS_PHACC = 8'h18; // accumulated phase
  localparam logic [7:0] SRPC_OFS_STATUS = 8'h1C; // live state
  // destination codes in the low four bits
  localparam logic [3:0] SRPC_CODE_MAIN = 4'h0;
  localparam logic [3:0] SRPC_CODE_PHASE = 4'h3;
  localparam logic [3:0] SRPC_CODE_REFCTL = 4'h4;
  localparam logic [3:0] SRPC_CODE_RESV = 4'h5;
  localparam logic [3:0] SRPC_CODE_OUTREG = 4'h6;
  // main register fields
  localparam int SRPC_MAIN_AUTOCAL = 21;
  // phase register fields
  localparam int SRPC_PH_LOAD_RST_DIS = 30;
  localparam int SRPC_PH_ADJ_EN = 28;
  localparam int SRPC_PH_VAL_LSB = 4;
  localparam int SRPC_PH_W = 24;
  // reference and pump control fields
  localparam int SRPC_RC_MUX_LSB = 27;
  localparam int SRPC_RC_DOUBLER = 26;
  localparam int SRPC_RC_HALVE = 25;
  localparam int SRPC_RC_RDIV_LSB = 15;
  localparam int SRPC_RC_DBUF = 14;
  localparam int SRPC_RC_PUMP_LSB = 10;
  localparam int SRPC_RC_REFMODE = 9;
  localparam int SRPC_RC_LEVEL = 8;
  localparam int SRPC_RC_POL = 7;
  localparam int SRPC_RC_PDOWN = 6;
  localparam int SRPC_RC_TRI = 5;
  localparam int SRPC_RC_CRST = 4;
  // output register divider select field
  localparam int SRPC_OR_DIV_LSB = 21;
  // values after reset
  localparam logic [31:0] SRPC_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] SRPC_RST_REFCTL = 32'h0000_0004;
  localparam logic [31:0] SRPC_RST_MAIN = 32'h0000_0000;
  localparam logic [31:0] SRPC_RST_PHASE = 32'h0000_0003;
  localparam logic [31:0] SRPC_RST_OUTREG = 32'h0000_0006;
  localparam logic [31:0] SRPC_RST_RESV = 32'h0000_0005;
  localparam logic [31:0] SRPC_RESV_FIXED = 32'h0080_0025;
endpackage

// >>> tb/srpc_sva.sv
// checker for the reference/pump control bank, sees top ports only
// assumes it is bound onto srpc_top from the testbench file
`timescale 1ns/1ps
`default_nettype none
module srpc_sva (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pfd_clock_o,
  input wire logic [2:0] test_output_mux_o,
  input wire logic [3:0] pump_current_field_o,
  input wire logic mux_logic_level_select_o,
  input wire logic detector_polarity_o,
  input wire logic pump_three_state_o,
  input wire logic counters_hold_o,
  input wire logic counters_load_o,
  input wire logic vco_enable_o,
  input wire logic rf_outputs_enable_o,
  input wire logic lock_detect_reset_o,
  input wire logic vco_autocal_start_o,
  input wire logic modulator_reset_o,
  input wire logic [2:0] output_divider_select_o,
  input wire logic [23:0] phase_accum_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // a fresh request, and a counter hold lasting four cycles
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_held; counters_hold_o [*4]; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_pd; counters_load_o |-> pump_three_state_o && counters_hold_o
    && !vco_enable_o && !rf_outputs_enable_o && lock_detect_reset_o;
  endproperty
  property p_run; !counters_load_o |-> vco_enable_o && rf_outputs_enable_o
    && !lock_detect_reset_o; endproperty
  property p_ctl; $changed({test_output_mux_o, pump_current_field_o,
    mux_logic_level_select_o, detector_polarity_o}) |-> wb_ack_o;
  endproperty
  property p_ph; $changed(phase_accum_o) |-> wb_ack_o; endproperty
  property p_div; $changed(output_divider_select_o) |-> wb_ack_o; endproperty
  property p_tri; $changed(pump_three_state_o) |-> wb_ack_o; endproperty
  property p_mr; modulator_reset_o |-> wb_ack_o ##1 !modulator_reset_o;
  endproperty
  property p_ac; vco_autocal_start_o |-> wb_ack_o ##1 !vco_autocal_start_o;
  endproperty
  // the comparison clock may not move once the counters have been held four cycles
  property p_hold; s_held |-> $stable(pfd_clock_o); endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  a_pd: assert property (p_pd) else $error("power-down set");
  a_run: assert property (p_run) else $error("run state");
  a_ctl: assert property (p_ctl) else $error("ctl moved");
  a_ph: assert property (p_ph) else $error("phase moved");
  a_div: assert property (p_div) else $error("div moved");
  a_tri: assert property (p_tri) else $error("tri moved");
  a_mr: assert property (p_mr) else $error("mod reset");
  a_ac: assert property (p_ac) else $error("autocal");
  a_hold: assert property (p_hold) else $error("held pfd");
endmodule
`default_nettype wire

// >>> tb/srpc_host.sv
// host controller model: classic wishbone master writing config words
// assumes a slave that answers with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module srpc_host (
  input wire logic clock_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // one cycle, held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <=
      {2'b11, w, a, 4'hF, d};
    // no cycle count is assumed; only the bench watchdog ends a hang
    do begin
      @(posedge clock_i);
    end while (ack_i !== 1'b1);
    q = rdat_i;
    // released data shows the inverse, never the stale word
    {cyc_o, stb_o, we_o, dat_o} <= {3'b000, ~d};
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the reference/pump control bank
// assumes srpc_top, srpc_host and srpc_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srpc_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reference_input_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pfd_clock_o, pfd_q;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, pump_current_field_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0] test_output_mux_o, output_divider_select_o;
  logic mux_logic_level_select_o, detector_polarity_o, pump_three_state_o;
  logic differential_reference_o, counters_hold_o, counters_load_o;
  logic vco_enable_o, rf_outputs_enable_o, lock_detect_reset_o;
  logic vco_autocal_start_o, modulator_reset_o;
  logic [23:0] phase_accum_o;
  int errors = 0;
  int comparisons = 0;
  int pc, mr, ac; // pfd rising edges, modulator resets, autocal starts
  wire [5:0] pdv = {counters_load_o, counters_hold_o, pump_three_state_o,
    vco_enable_o, rf_outputs_enable_o, lock_detect_reset_o};
  srpc_top u_dut (.clock_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .reference_input_i, .pfd_clock_o, .test_output_mux_o,
    .mux_logic_level_select_o, .detector_polarity_o, .pump_current_field_o,
    .pump_three_state_o, .differential_reference_o, .counters_hold_o,
    .counters_load_o, .vco_enable_o, .rf_outputs_enable_o,
    .lock_detect_reset_o, .vco_autocal_start_o, .modulator_reset_o,
    .output_divider_select_o, .phase_accum_o);
  srpc_host u_host (.clock_i, .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
    .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
    .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  always #12.5 clock_i = ~clock_i;
  // free-running reference, sixteen clocks a period
  always begin
    repeat (8) @(posedge clock_i);
    reference_input_i <= ~reference_input_i;
  end
  // event counters on the design's outputs
  always @(posedge clock_i) begin
    pfd_q <= pfd_clock_o;
    if (pfd_clock_o && !pfd_q) pc++;
    if (modulator_reset_o) mr++;
    if (vco_autocal_start_o) ac++;
  end
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // write, then let the ack edge's updates land
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
    @(posedge clock_i);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask
  task automatic t_reset;
    chk("rst", 6'b000110, pdv);
    r(SRPC_OFS_REFCTL, SRPC_RST_REFCTL, "refctl");
  endtask
  // phase adds and wraps with modulator reset disabled, then one main write gives one mod reset and one autocal start
  task automatic t_phase;
    mr = 0;
    ac = 0;
    w(SRPC_OFS_WORD, 32'h5FFFFF03);
    w(SRPC_OFS_WORD, 32'h00000010);
    w(SRPC_OFS_WORD, 32'h00000010);
    chk("acc", 32'h00FFFFE0, phase_accum_o);
    chk("cnt", 32'h0, {mr[15:0], ac[15:0]});
    w(SRPC_OFS_WORD, 32'h00000103);
    w(SRPC_OFS_WORD, 32'h00200000);
    chk("acc", 32'h00FFFFE0, phase_accum_o);
    chk("cnt", 32'h00010001, {mr[15:0], ac[15:0]});
  endtask
  task automatic t_ref;
    logic [31:0] wd [4];
    int ex [4];
    logic [9:0] ctl; // control copies plus reference mode
    wd = '{32'h28022984, 32'h2C022984, 32'h2A022984, 32'h2800AB84};
    ex = '{10, 20, 5, 40};
    for (int i = 0; i < 4; i++) begin
      w(SRPC_OFS_WORD, wd[i]);
      repeat (32) @(posedge clock_i);
      pc = 0;
      repeat (640) @(posedge clock_i);
      comparisons++;
      if (pc < ex[i] - 1 || pc > ex[i] + 1) begin
        errors++;
        $display("[ERR] pfd exp %0d got %0d", ex[i], pc);
      end
    end
    ctl = {test_output_mux_o, pump_current_field_o,
      mux_logic_level_select_o, detector_polarity_o,
      differential_reference_o};
    chk("ctl", 10'h2D7, ctl);
  endtask
  task automatic t_pd;
    w(SRPC_OFS_WORD, 32'h280229C4);
    chk("pd", 6'b111001, pdv);
    w(SRPC_OFS_WORD, 32'h00000233);
    r(SRPC_OFS_PHASE, 32'h00000233, "ph");
    r(SRPC_OFS_REFCTL, 32'h280229C4, "rc");
    w(SRPC_OFS_WORD, 32'h280229A4);
    chk("tri", 6'b001110, pdv);
    w(SRPC_OFS_WORD, 32'h28022994);
    repeat (8) @(posedge clock_i);
    chk("crst", 6'b010110, pdv);
    w(SRPC_OFS_WORD, 32'h28022984);
    chk("run", 6'b000110, pdv);
  endtask
  task automatic t_dbuf;
    w(SRPC_OFS_WORD, 32'h00026984);
    w(SRPC_OFS_WORD, 32'h00600006);
    chk("div", 3'd0, output_divider_select_o);
    w(SRPC_OFS_WORD, 32'h00000010);
    chk("div", 3'd3, output_divider_select_o);
    w(SRPC_OFS_WORD, 32'h00022984);
    w(SRPC_OFS_WORD, 32'h00A00006);
    chk("div", 3'd5, output_divider_select_o);
  endtask
  task automatic t_resv;
    w(SRPC_OFS_WORD, SRPC_RESV_FIXED);
    r(SRPC_OFS_RESV, SRPC_RESV_FIXED, "resv");
    // direct control write: code forced, counters held, status read back
    w(SRPC_OFS_REFCTL, 32'h00022990);
    r(SRPC_OFS_REFCTL, 32'h00022994, "direct");
    r(SRPC_OFS_WORD, 32'h00022994, "word");
    r(SRPC_OFS_STATUS, 32'h0000005A, "stat");
    w(SRPC_OFS_MAIN, 32'hFFFFFFF0);
    r(SRPC_OFS_MAIN, 32'h00000010, "main");
    r(8'hF0, 32'h0, "unmap");
  endtask
  task automatic complete_run;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_phase();
    t_ref();
    t_pd();
    t_dbuf();
    t_resv();
    complete_run();
  end
  // watchdog: the run needs about 2800 clocks
  initial begin
    #250000;
    errors++;
    complete_run();
  end
endmodule
bind srpc_top srpc_sva u_sva (.clock_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .pfd_clock_o, .test_output_mux_o, .pump_current_field_o,
  .mux_logic_level_select_o, .detector_polarity_o, .pump_three_state_o,
  .counters_hold_o, .counters_load_o, .vco_enable_o, .rf_outputs_enable_o,
  .lock_detect_reset_o, .vco_autocal_start_o, .modulator_reset_o,
  .output_divider_select_o, .phase_accum_o);
`default_nettype wire
